/* File: rtl/channel_fault.v */
// per channel overvoltage qualifier and undervoltage pulse timer
`timescale 1ns/1ps
`include "fault_defs.vh"

module channel_fault #(
    parameter OV_CYC    = `OV_DELAY_CYC,
    parameter OV_W      = 10,
    parameter UV_PULSES = `UV_PULSES,
    parameter UV_W      = 13
) (
    // clock and reset
    input  wire clock,
    input  wire rst_sync_b,
    // comparators and timing
    input  wire ov_cmp,
    input  wire uv_cmp,
    input  wire osc_pulse,
    input  wire latch_clear,
    // state
    output reg  ov_latch_reg,
    output reg  uv_latch_reg,
    output reg  uv_flag_reg
);

    reg [OV_W-1:0] ov_cnt_reg;
    reg [UV_W-1:0] uv_cnt_reg;

    // overvoltage must persist for the qualifying delay before latching
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ov_cnt_reg   <= {OV_W{1'b0}};
            ov_latch_reg <= 1'b0;
        end else if (latch_clear) begin
            ov_cnt_reg   <= {OV_W{1'b0}};
            ov_latch_reg <= 1'b0;
        end else if (!ov_cmp) begin
            ov_cnt_reg   <= {OV_W{1'b0}};
        end else if (ov_cnt_reg == OV_CYC[OV_W-1:0] - 1'b1) begin
            ov_latch_reg <= 1'b1;
        end else begin
            ov_cnt_reg   <= ov_cnt_reg + 1'b1;
        end
    end

    // undervoltage flag and oscillator pulse counter
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            uv_cnt_reg   <= {UV_W{1'b0}};
            uv_latch_reg <= 1'b0;
            uv_flag_reg  <= 1'b0;
        end else begin
            uv_flag_reg <= uv_cmp;
            if (latch_clear) begin
                uv_cnt_reg   <= {UV_W{1'b0}};
                uv_latch_reg <= 1'b0;
            end else if (!uv_cmp) begin
                uv_cnt_reg <= {UV_W{1'b0}};
            end else if (osc_pulse) begin
                if (uv_cnt_reg == UV_PULSES[UV_W-1:0] - 1'b1)
                    uv_latch_reg <= 1'b1;
                else
                    uv_cnt_reg <= uv_cnt_reg + 1'b1;
            end
        end
    end

endmodule

/* File: rtl/dual_channel_fault_protection.v */
// top of the dual channel fault protection block with its register slave
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "fault_defs.vh"

module dual_channel_fault_protection #(
    parameter UV_PULSES   = `UV_PULSES,
    parameter CASC_DLY    = `CASCADE_DLY_CYC,
    parameter RESTART_CYC = `RESTART_CYC,
    parameter CNT_W       = 8
) (
    // clock and reset
    input  wire        clock,
    input  wire        rst_b,
    // pins
    input  wire        channel_one_enable,
    input  wire        channel_two_enable,
    input  wire        dual_mode_sel,
    input  wire        cascade_sel,
    input  wire        input_supply_uvlo,
    input  wire        osc_pulse,
    // per channel comparators and pwm demand
    input  wire [1:0]  ov_cmp,
    input  wire [1:0]  uv_cmp,
    input  wire [1:0]  ls_oc_cmp,
    input  wire [1:0]  hs_oc_cmp,
    input  wire [1:0]  pwm_hs_req,
    // drivers and discharge
    output reg  [1:0]  hs_drive_reg,
    output reg  [1:0]  ls_drive_reg,
    output reg         channel_one_discharge_pin_reg,
    output reg         channel_two_discharge_pin_reg,
    output reg  [1:0]  soft_start_node_discharge_reg,
    output reg  [1:0]  uv_flag_out_reg,
    output reg         irq_reg,
    // axi4-lite write address
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // cascade supervisor states
    localparam ST_RUN     = 3'b001;
    localparam ST_QUALIFY = 3'b010;
    localparam ST_RESTART = 3'b100;

    //------------------------------------------------------------
    // reset release
    //------------------------------------------------------------
    reg rst_meta_reg;
    reg rst_sync_b;

    // two flops release the asynchronous reset
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_b   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_b   <= rst_meta_reg;
        end
    end

    //------------------------------------------------------------
    // fault latch clearing
    //------------------------------------------------------------
    wire [1:0] en = {channel_two_enable, channel_one_enable};
    reg        both_low_reg;
    wire       latch_clear;

    // remembers that both enables went low while in memory mode
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b)
            both_low_reg <= 1'b0;
        else if (en == 2'b00)
            both_low_reg <= !dual_mode_sel;
        else
            both_low_reg <= 1'b0;
    end

    // supply cycling, all three pins low, or an enable toggle in memory mode
    assign latch_clear = input_supply_uvlo
        | (!dual_mode_sel & (en == 2'b00))
        | (both_low_reg & !dual_mode_sel & (en != 2'b00));

    //------------------------------------------------------------
    // per channel fault and overcurrent logic
    //------------------------------------------------------------
    wire [1:0] ov_latch;
    wire [1:0] uv_latch;
    wire [1:0] uv_flag;
    wire [1:0] extend;
    wire [1:0] armed;
    wire [1:0] term;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            channel_fault #(
                .UV_PULSES (UV_PULSES)
            ) u_fault (
                .clock        (clock),
                .rst_sync_b   (rst_sync_b),
                .ov_cmp       (ov_cmp[ch]),
                .uv_cmp       (uv_cmp[ch]),
                .osc_pulse    (osc_pulse),
                .latch_clear  (latch_clear),
                .ov_latch_reg (ov_latch[ch]),
                .uv_latch_reg (uv_latch[ch]),
                .uv_flag_reg  (uv_flag[ch])
            );
            // high side sensing is unused in cascade configuration
            ocp_channel u_ocp (
                .clock      (clock),
                .rst_sync_b (rst_sync_b),
                .enable     (en[ch] & !cascade_sel),
                .pwm_hs_req (pwm_hs_req[ch]),
                .osc_pulse  (osc_pulse),
                .ls_oc_cmp  (ls_oc_cmp[ch]),
                .hs_oc_cmp  (hs_oc_cmp[ch]),
                .extend_reg (extend[ch]),
                .arm_reg    (armed[ch]),
                .term_reg   (term[ch])
            );
        end
    endgenerate

    //------------------------------------------------------------
    // cascade overcurrent supervisor
    //------------------------------------------------------------
    reg  [2:0]       casc_state_reg;
    reg  [CNT_W-1:0] casc_cnt_reg;
    wire             casc_oc = cascade_sel & |(ls_oc_cmp & en);
    wire             casc_trip = (casc_state_reg == ST_QUALIFY) & casc_oc
                                 & (casc_cnt_reg == CASC_DLY[CNT_W-1:0] - 1'b1);
    wire             restarting = (casc_state_reg == ST_RESTART);

    // short qualify, then both channels off and restarted from soft-start
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            casc_state_reg <= ST_RUN;
            casc_cnt_reg   <= {CNT_W{1'b0}};
        end else begin
            case (casc_state_reg)
                ST_RUN: begin
                    casc_cnt_reg <= {CNT_W{1'b0}};
                    if (casc_oc)
                        casc_state_reg <= ST_QUALIFY;
                end
                ST_QUALIFY: begin
                    if (!casc_oc) begin
                        casc_state_reg <= ST_RUN;
                    end else if (casc_trip) begin
                        casc_state_reg <= ST_RESTART;
                        casc_cnt_reg   <= {CNT_W{1'b0}};
                    end else begin
                        casc_cnt_reg <= casc_cnt_reg + 1'b1;
                    end
                end
                ST_RESTART: begin
                    if (casc_cnt_reg == RESTART_CYC[CNT_W-1:0] - 1'b1)
                        casc_state_reg <= ST_RUN;
                    else
                        casc_cnt_reg <= casc_cnt_reg + 1'b1;
                end
                default: begin
                    casc_state_reg <= ST_RUN;
                    casc_cnt_reg   <= {CNT_W{1'b0}};
                end
            endcase
        end
    end

    //------------------------------------------------------------
    // drivers, discharge and soft-start
    //------------------------------------------------------------
    wire       latched = |ov_latch | |uv_latch;
    wire [1:0] chan_off = ~en | {2{input_supply_uvlo | latched | restarting}};
    wire [1:0] hs_next = pwm_hs_req & ~chan_off & ~extend & ~term;
    wire [1:0] ls_next = (~chan_off & ~hs_next) | ov_latch;

    // registered gate controls; overvoltage holds the low side on
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            hs_drive_reg                  <= 2'b00;
            ls_drive_reg                  <= 2'b00;
            channel_one_discharge_pin_reg <= 1'b0;
            channel_two_discharge_pin_reg <= 1'b0;
            soft_start_node_discharge_reg <= 2'b11;
            uv_flag_out_reg               <= 2'b00;
        end else begin
            hs_drive_reg    <= hs_next & ~ov_latch & ~uv_latch;
            ls_drive_reg    <= ls_next & ~(uv_latch & ~ov_latch);
            uv_flag_out_reg <= uv_flag;
            // off channel drains its output; a latched fault on either channel drains both
            channel_one_discharge_pin_reg <= chan_off[0];
            channel_two_discharge_pin_reg <= chan_off[1];
            soft_start_node_discharge_reg <= chan_off;
        end
    end

    //------------------------------------------------------------
    // event status and interrupt
    //------------------------------------------------------------
    reg  [`ST_W-1:0] status_reg;
    reg  [`ST_W-1:0] mask_reg;
    reg  [5:0]       prev_reg;
    reg              term_d_reg;
    wire [5:0]       now_bits = {uv_flag, uv_latch, ov_latch};
    wire [`ST_W-1:0] events = {(|term) & !term_d_reg, casc_trip, now_bits & ~prev_reg};
    wire [`ST_W-1:0] w1c;
    wire             do_write;

    // sticky bits; a new event wins over a write-one clear
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            status_reg <= {`ST_W{1'b0}};
            prev_reg   <= 6'h00;
            term_d_reg <= 1'b0;
            irq_reg    <= 1'b0;
        end else begin
            prev_reg   <= now_bits;
            term_d_reg <= |term;
            status_reg <= (status_reg & ~w1c) | events;
            irq_reg    <= |(status_reg & mask_reg);
        end
    end

    //------------------------------------------------------------
    // axi4-lite slave
    //------------------------------------------------------------
    reg  [`ADDR_W-1:0] aw_addr_reg;
    reg  [31:0]        w_data_reg;
    reg                w_strb0_reg;
    reg                aw_have_reg;
    reg                w_have_reg;
    wire               aw_take = s_axi_awvalid & s_axi_awready;
    wire               w_take = s_axi_wvalid & s_axi_wready;
    wire               ar_take = s_axi_arvalid & s_axi_arready;

    assign do_write = aw_have_reg & w_have_reg & !s_axi_bvalid;
    assign w1c = (do_write & w_strb0_reg & (aw_addr_reg == `REG_STATUS))
                 ? w_data_reg[`ST_W-1:0] : {`ST_W{1'b0}};

    // map check shared by reads and writes
    function mapped;
        input [`ADDR_W-1:0] a;
        begin
            mapped = (a == `REG_STATUS) | (a == `REG_MASK) | (a == `REG_STATE);
        end
    endfunction

    // write channels taken in either order, answer after both
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= {`ADDR_W{1'b0}};
            w_data_reg    <= 32'h0000_0000;
            w_strb0_reg   <= 1'b0;
            mask_reg      <= {`ST_W{1'b0}};
        end else begin
            s_axi_awready <= !aw_have_reg & !aw_take & !s_axi_bvalid;
            s_axi_wready  <= !w_have_reg & !w_take & !s_axi_bvalid;
            if (aw_take) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr[`ADDR_W-1:0];
            end
            if (w_take) begin
                w_have_reg  <= 1'b1;
                w_data_reg  <= s_axi_wdata;
                w_strb0_reg <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
                if (w_strb0_reg && aw_addr_reg == `REG_MASK)
                    mask_reg <= w_data_reg[`ST_W-1:0];
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one cycle from address to data
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid & !ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= mapped(s_axi_araddr[`ADDR_W-1:0])
                                ? `RESP_OKAY : `RESP_SLVERR;
                case (s_axi_araddr[`ADDR_W-1:0])
                    `REG_STATUS: s_axi_rdata <= {24'h000000, status_reg};
                    `REG_MASK:   s_axi_rdata <= {24'h000000, mask_reg};
                    `REG_STATE:  s_axi_rdata <= {19'h00000, casc_state_reg, armed,
                                                 extend, uv_flag, uv_latch, ov_latch};
                    default:     s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

/* File: rtl/fault_defs.vh */
// constants for the dual channel fault protection block
//------------------------------------------------------------
//------------------------------------------------------------
`ifndef FAULT_DEFS_VH
`define FAULT_DEFS_VH

// timing
`define CLK_MHZ          40
`define OV_DELAY_NS      20000
`define OV_DELAY_CYC     ((`OV_DELAY_NS * `CLK_MHZ + 999) / 1000)
`define UV_PULSES        4096
`define CASCADE_DLY_CYC  4
`define RESTART_CYC      64

// register byte addresses
`define ADDR_W           4
`define REG_STATUS       4'h0
`define REG_MASK         4'h4
`define REG_STATE        4'h8

// status / mask bit layout
`define ST_W             8
`define ST_OV0           0
`define ST_OV1           1
`define ST_UV0           2
`define ST_UV1           3
`define ST_UVF0          4
`define ST_UVF1          5
`define ST_CASC          6
`define ST_TERM          7

// bus answers
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

/* File: rtl/ocp_channel.v */
// cycle by cycle overcurrent: low side extension and high side termination
`timescale 1ns/1ps

module ocp_channel (
    // clock and reset
    input  wire clock,
    input  wire rst_sync_b,
    // control
    input  wire enable,
    input  wire pwm_hs_req,
    input  wire osc_pulse,
    // comparators
    input  wire ls_oc_cmp,
    input  wire hs_oc_cmp,
    // state
    output reg  extend_reg,
    output reg  arm_reg,
    output reg  term_reg
);

    reg hs_req_d_reg;

    // extension lasts until the next period's oscillator pulse
    always @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            extend_reg   <= 1'b0;
            arm_reg      <= 1'b0;
            term_reg     <= 1'b0;
            hs_req_d_reg <= 1'b0;
        end else begin
            hs_req_d_reg <= pwm_hs_req;
            if (!enable) begin
                extend_reg <= 1'b0;
                arm_reg    <= 1'b0;
            end else if (ls_oc_cmp && (!pwm_hs_req || extend_reg)) begin
                extend_reg <= 1'b1;
                arm_reg    <= 1'b1;
            end else begin
                if (osc_pulse)
                    extend_reg <= 1'b0;
                if (hs_req_d_reg && !pwm_hs_req && !extend_reg)
                    arm_reg <= 1'b0;
            end
            // terminated pulse stays off until the request ends
            if (!enable || !pwm_hs_req)
                term_reg <= 1'b0;
            else if (arm_reg && !extend_reg && hs_oc_cmp)
                term_reg <= 1'b1;
        end
    end

endmodule

/* File: verif/dual_channel_fault_protection_props.sv */
// concurrent checks on the block's pins
`timescale 1ns/1ps
module dual_channel_fault_protection_props #(
    parameter UV_PULSES = 4096
) (
    // clock and reset
    input wire       clock,
    input wire       rst_b,
    // pins and comparators
    input wire       channel_one_enable,
    input wire       channel_two_enable,
    input wire       dual_mode_sel,
    input wire       cascade_sel,
    input wire       input_supply_uvlo,
    input wire       osc_pulse,
    input wire [1:0] ov_cmp,
    input wire [1:0] uv_cmp,
    input wire [1:0] ls_oc_cmp,
    input wire [1:0] pwm_hs_req,
    // drivers and discharge
    input wire [1:0] hs_drive_reg,
    input wire [1:0] ls_drive_reg,
    input wire       channel_one_discharge_pin_reg,
    input wire [1:0] soft_start_node_discharge_reg,
    input wire [1:0] uv_flag_out_reg
);
    // clear condition at the pins
    wire        clr = input_supply_uvlo | ~(dual_mode_sel | channel_one_enable | channel_two_enable);
    wire        casc0 = cascade_sel & channel_one_enable & ls_oc_cmp[0];
    reg  [10:0] ov_cnt_reg;
    reg  [15:0] uv_cnt_reg;
    reg         ov_seen_reg;

    // overvoltage cycles, pulses under undervoltage
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ov_cnt_reg  <= 11'h0;
            uv_cnt_reg  <= 16'h0;
            ov_seen_reg <= 1'b0;
        end else begin
            ov_cnt_reg  <= (ov_cmp[0] & ~clr) ? ov_cnt_reg + {10'h0, ~&ov_cnt_reg} : 11'h0;
            uv_cnt_reg  <= (uv_cmp[0] & ~clr) ? uv_cnt_reg + {15'h0, osc_pulse} : 16'h0;
            ov_seen_reg <= ~clr & (ov_seen_reg | (ov_cnt_reg > 11'd810));
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    ov_hold_a: assert property (ov_cnt_reg > 11'd810 |->
        !hs_drive_reg[0] && ls_drive_reg[0]) else $error("ov drivers");
    ov_dis_a: assert property (ov_cnt_reg > 11'd810 |->
        channel_one_discharge_pin_reg) else $error("ov discharge");
    latch_keep_a: assert property (ov_seen_reg && !clr |->
        !hs_drive_reg[0]) else $error("latch lost");
    uv_flag_a: assert property (uv_cmp[0] [*3] |->
        uv_flag_out_reg[0]) else $error("uv flag");
    uv_latch_a: assert property (uv_cnt_reg > UV_PULSES |-> ##2
        hs_drive_reg == 2'b00 && ls_drive_reg == 2'b00 && channel_one_discharge_pin_reg)
        else $error("uv latch-off");
    ls_ext_a: assert property ((ls_oc_cmp[0] && !pwm_hs_req[0] && !osc_pulse
        && channel_one_enable && !cascade_sel && !input_supply_uvlo) ##1 !osc_pulse [*2]
        |-> ls_drive_reg[0] && !hs_drive_reg[0]) else $error("no extension");
    casc_off_a: assert property (casc0 [*4] |-> ##[1:3]
        hs_drive_reg == 2'b00 && ls_drive_reg == 2'b00) else $error("cascade late");
    casc_ss_a: assert property (casc0 [*4] |-> ##[1:6]
        soft_start_node_discharge_reg == 2'b11 ##[55:75] soft_start_node_discharge_reg == 2'b00)
        else $error("cascade restart");
    ss_en_a: assert property (!channel_two_enable [*2] |=>
        soft_start_node_discharge_reg[1] && !hs_drive_reg[1]) else $error("disabled channel on");
    uvlo_ss_a: assert property (input_supply_uvlo [*2] |=>
        soft_start_node_discharge_reg == 2'b11 && hs_drive_reg == 2'b00)
        else $error("lockout ignored");
endmodule

bind dual_channel_fault_protection dual_channel_fault_protection_props #(
    .UV_PULSES(UV_PULSES)
) props (.*);

/* File: verif/dual_channel_fault_protection_tb_top.sv */
// self-checking bench for the fault protection block
`timescale 1ns/1ps
module dual_channel_fault_protection_tb_top;
    logic        clock = 1'b0, rst_b = 1'b0, run = 1'b0;
    logic        channel_one_enable = 1'b0, channel_two_enable = 1'b0, dual_mode_sel = 1'b0;
    logic        cascade_sel = 1'b0, input_supply_uvlo = 1'b0, osc_pulse = 1'b0;
    logic [1:0]  ov_cmp = 2'h0, uv_cmp = 2'h0, pwm_hs_req = 2'h0, ls_load = 2'h0, hs_load = 2'h0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, rdat;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [2:0]  ph = 3'h0;
    logic [1:0]  rresp;
    wire  [1:0]  ls_oc_cmp, hs_oc_cmp, hs_drive_reg, ls_drive_reg, uv_flag_out_reg;
    wire  [1:0]  soft_start_node_discharge_reg, s_axi_bresp, s_axi_rresp;
    wire         channel_one_discharge_pin_reg, channel_two_discharge_pin_reg, irq_reg;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [31:0] s_axi_rdata;
    int          error_cnt = 0, checks_done = 0;

    // block with a short undervoltage count
    dual_channel_fault_protection #(.UV_PULSES(8)) uut (.*);
    power_stage_model stage (.*);

    // 40 MHz clock
    initial begin
        forever #12.5 clock = ~clock;
    end

    // pulse every 8 clocks, high side for 3
    always @(posedge clock) begin
        ph         <= ph + 3'h1;
        osc_pulse  <= run && (ph == 3'h7);
        pwm_hs_req <= {2{run && (ph < 3'h3)}};
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // write: aw and w together, each dropped when taken
    task automatic wr(input logic [31:0] a, d);
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rresp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a);
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        rresp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #250us;
        error_cnt++;
        $display("FAIL watchdog expected end seen hang");
        report_and_stop;
    end

    initial begin
        cyc(20);
        rst_b <= 1'b1;
        cyc(4);
        rd(32'h0);
        chk("status", rdat, 32'h0);
        rd(32'hc);
        chk("hole resp", rresp, 32'h2);
        chk("hole data", rdat, 32'h0);
        chk("ss off", soft_start_node_discharge_reg, 32'h3);
        dual_mode_sel <= 1'b1;
        cyc(2);
        {channel_one_enable, channel_two_enable} <= 2'h3;
        run <= 1'b1;
        cyc(20);
        chk("ss run", soft_start_node_discharge_reg, 32'h0);
        $display("startup done");
        // overvoltage on channel one, irq enabled
        wr(32'h4, 32'h1);
        chk("wr resp", rresp, 32'h0);
        ov_cmp <= 2'h1;
        cyc(780);
        rd(32'h8);
        chk("ov early", rdat[1:0], 32'h0);
        cyc(30);
        chk("ov hs", hs_drive_reg[0], 32'h0);
        chk("ov ls", ls_drive_reg[0], 32'h1);
        chk("ov dis", channel_one_discharge_pin_reg, 32'h1);
        chk("ov dis2", channel_two_discharge_pin_reg, 32'h1);
        chk("irq", irq_reg, 32'h1);
        ov_cmp <= 2'h0;
        cyc(40);
        chk("ov kept", hs_drive_reg[0], 32'h0);
        rd(32'h0);
        chk("ov status", rdat[0], 32'h1);
        wr(32'h4, 32'h0);
        cyc(3);
        chk("irq masked", irq_reg, 32'h0);
        dual_mode_sel <= 1'b0;
        {channel_one_enable, channel_two_enable} <= 2'h0;
        cyc(4);
        dual_mode_sel <= 1'b1;
        cyc(2);
        {channel_one_enable, channel_two_enable} <= 2'h3;
        cyc(20);
        wr(32'h0, 32'hff);
        rd(32'h8);
        chk("ov cleared", rdat[1:0], 32'h0);
        rd(32'h0);
        chk("status w1c", rdat, 32'h0);
        $display("test overvoltage done");
        // undervoltage: short episode, then a full one
        dual_mode_sel <= 1'b0;
        uv_cmp <= 2'h1;
        cyc(40);
        uv_cmp <= 2'h0;
        cyc(16);
        uv_cmp <= 2'h1;
        cyc(40);
        chk("uv flag", uv_flag_out_reg[0], 32'h1);
        rd(32'h8);
        chk("uv restart", rdat[3:2], 32'h0);
        cyc(40);
        chk("uv drivers", hs_drive_reg | ls_drive_reg, 32'h0);
        chk("uv dis", channel_one_discharge_pin_reg, 32'h1);
        uv_cmp <= 2'h0;
        {channel_one_enable, channel_two_enable} <= 2'h0;
        cyc(4);
        {channel_one_enable, channel_two_enable} <= 2'h3;
        cyc(20);
        rd(32'h8);
        chk("uv cleared", rdat[3:2], 32'h0);
        $display("test undervoltage done");
        // high side overcurrent alone, then armed
        wr(32'h0, 32'hff);
        hs_load <= 2'h1;
        cyc(24);
        rd(32'h0);
        chk("no arm", rdat[7], 32'h0);
        ls_load <= 2'h1;
        cyc(8);
        ls_load <= 2'h0;
        cyc(24);
        rd(32'h0);
        chk("hs ended", rdat[7], 32'h1);
        $display("test overcurrent done");
        // cascade: short trip ignored, long one shuts off
        hs_load <= 2'h0;
        cascade_sel <= 1'b1;
        wr(32'h0, 32'hff);
        while (ph != 3'h4) @(posedge clock);
        ls_load <= 2'h1;
        hs_load <= 2'h1;
        cyc(2);
        ls_load <= 2'h0;
        cyc(24);
        rd(32'h0);
        chk("casc low only", rdat[7:6], 32'h0);
        hs_load <= 2'h0;
        ls_load <= 2'h1;
        cyc(20);
        chk("casc off", hs_drive_reg | ls_drive_reg, 32'h0);
        chk("casc ss", soft_start_node_discharge_reg, 32'h3);
        ls_load <= 2'h0;
        rd(32'h0);
        chk("casc trip", rdat[6], 32'h1);
        cyc(80);
        chk("casc restart", soft_start_node_discharge_reg, 32'h0);
        $display("cascade done");
        input_supply_uvlo <= 1'b1;
        cyc(4);
        chk("uvlo ss", soft_start_node_discharge_reg, 32'h3);
        input_supply_uvlo <= 1'b0;
        cyc(10);
        $display("lockout done");
        report_and_stop;
    end
endmodule

/* File: verif/power_stage_model.sv */
// power stage model: switch drop flags under load
`timescale 1ns/1ps
module power_stage_model (
    // gate controls from the block
    input  wire [1:0] hs_drive_reg,
    input  wire [1:0] ls_drive_reg,
    // commanded overload
    input  wire [1:0] ls_load,
    input  wire [1:0] hs_load,
    // drop above setpoint
    output wire [1:0] ls_oc_cmp,
    output wire [1:0] hs_oc_cmp
);
    // only a conducting switch shows a drop; an idle one never trips
    assign ls_oc_cmp = ls_load & ls_drive_reg;
    assign hs_oc_cmp = hs_load & hs_drive_reg;
endmodule
